// ### testbench/memory_select_decoder_test.sv
// self-checking bench of msd_decoder against a behavioural decode model
// assumes msd_pkg compiled first and the bus model in msd_mcu_model
`timescale 1ns/100ps
`default_nettype none
module memory_select_decoder_test;
   import msd_pkg::*;
   logic clk_i = 0, rst_n_i = 0, go = 0, ext = 0, pwr_dn = 0, rdy = 0, done, f_n, r_n, w_n, oe;
   logic [1:0] kind = 0;
   logic [3:0] hold = 5;
   logic [19:0] a_req = 0, pa;
   logic [7:0] wd = 0, pd, dout, page_m = 8'h00, smap_m = 8'h0C, pgo, smo;
   logic [3:0] bsel;
   logic [23:0] pin = 0;
   logic [2:0] pdi = 0;
   logic [15:0] fb = 0;
   logic [7:0] msel;
   logic sram, cfg, pio;
   msd_lbus_t lb, lbx;
   int err_total = 0, comparisons = 0, seed = 32'h32d5;
   msd_mcu_model msd_mcu_model_i (.clk_i(clk_i), .go_i(go), .kind_i(kind), .addr_i(a_req), .wdata_i(wd),
      .hold_i(hold), .addr_o(pa), .data_o(pd), .fetch_n_o(f_n), .rd_n_o(r_n), .wr_n_o(w_n), .done_o(done));
   msd_decoder msd_decoder_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(pa), .data_i(pd),
      .program_fetch_strobe_n_i(f_n), .read_strobe_n_i(r_n), .write_strobe_n_i(w_n), .power_down_input_i(pwr_dn),
      .ext_addr_mode_i(ext), .port_in_i(pin), .port_d_in_i(pdi), .cell_feedback_i(fb), .boot_ready_i(rdy),
      .main_flash_sector_select_o(msel), .boot_sector_select_o(bsel), .sram_select_o(sram),
      .config_register_space_o(cfg), .periph_io_select_o(pio), .page_outputs_o(pgo), .space_mapping_o(smo),
      .logic_bus_o(lb), .data_o(dout), .data_oe_o(oe));
   initial forever #10 clk_i = ~clk_i;
   // ------------------------------------------
   // checks and model
   // ------------------------------------------
   task automatic cmp_val(input logic [79:0] got, input logic [79:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH at %0t: %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask
   // alt covers readings left open: gated region still blocking, periph io on fetch
   function automatic logic [14:0] exp_sel(int k, logic [15:0] a, logic [7:0] sm, logic [7:0] pg, bit alt);
      logic f, s, c, p, b, m, hb, bb;
      logic [14:0] r;
      f = (k == 0);
      s = (a[15:11] == 5'h10) && (!f || sm[0]);
      c = (a[15:8] == 8'hB0) && !f;
      p = (a[15:12] == 4'hC) && sm[7] && (!f || alt);
      b = (a[15:13] == 3'h4) && (f ? sm[1] : sm[3]);
      m = a[15] && (f ? sm[2] : sm[4]);
      hb = alt ? (a[15:11] == 5'h10 || a[15:8] == 8'hB0 || (a[15:12] == 4'hC && sm[7])) : (s || c || p);
      bb = alt ? (a[15:13] == 3'h4) : b;
      r = 15'h0000;
      if (s) r[2] = 1'b1;
      else if (c) r[1] = 1'b1;
      else if (p) r[0] = 1'b1;
      else if (!hb && b) r[3 + a[12:11]] = 1'b1;
      else if (!hb && !bb && m) r[7 + {pg[1:0], a[14]}] = 1'b1;
      return r;
   endfunction
   task automatic cmp_sel(input int k, input logic [15:0] a);
      logic [14:0] got, e0, e1;
      got = {msel, bsel, sram, cfg, pio};
      e0 = exp_sel(k, a, smap_m, page_m, 1'b0);
      e1 = exp_sel(k, a, smap_m, page_m, 1'b1);
      cmp_val(80'($onehot0(got)), 80'h1, "one select");
      if (e0 === e1) cmp_val(80'(got), 80'(e0), "selects");
   endtask
   task automatic acc(input int k, input logic [19:0] a, input logic [7:0] d);
      int n;
      bit rreg;
      @(posedge clk_i);
      {kind, a_req, wd, go} <= {k[1:0], a, d, 1'b1};
      hold <= 4'(5 + {$random(seed)} % 4);
      {ext, pwr_dn, rdy, pin, pdi, fb} <= 46'({$random(seed), $random(seed), $random(seed)});
      n = 0;
      do begin
         @(posedge clk_i);
         #1 n++;
      end while (done !== 1'b1 && n < 40);
      if (n >= 40) cmp_val(80'h0, 80'h1, "bus handshake");
      // a register write has landed well before done, so the model moves first
      if (k == 2 && a[15:0] == 16'hB0E0) page_m = d;
      if (k == 2 && a[15:0] == 16'hB0C0) smap_m = d & 8'h9F;
      cmp_sel(k, a[15:0]);
      rreg = (k == 1) && (a[15:0] == 16'hB0E0 || a[15:0] == 16'hB0C0);
      cmp_val(80'(oe), 80'(rreg), "read drive");
      if (rreg) cmp_val(80'(dout), 80'(a[5] ? page_m : smap_m), "read data");
      cmp_val({pgo, smo}, {page_m, smap_m}, "register outputs");
      lbx = '{addr: ext ? a[19:4] : a[15:0], bus_ctl: {k == 0, k == 1, k == 2}, rst: 1'b0, pwr_dn: pwr_dn,
              port_in: pin, pd_in: pdi, page: page_m, fb: fb, rdy: rdy};
      cmp_val(80'(lb), 80'(lbx), "logic bus");
      @(posedge clk_i);
      go <= 1'b0;
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ------------------------------------------
   // scenarios
   // ------------------------------------------
   initial begin
      logic [7:0] sms [7];
      logic [15:0] adr [10];
      sms = '{8'h00, 8'h0C, 8'h14, 8'h1F, 8'h9F, 8'h8B, 8'hFF};
      // fixed regions: sectors disjoint and within their size
      adr = '{16'h4000, 16'h8000, 16'h87FF, 16'h8800, 16'h9FFF, 16'hA000, 16'hB0E0, 16'hC123, 16'hE000, 16'hFFFF};
      repeat (5) @(posedge clk_i);
      #1 cmp_val({pgo, smo, msel, bsel, sram, cfg, pio, oe}, {8'h00, 8'h0C, 16'h0}, "reset");
      @(posedge clk_i);
      rst_n_i <= 1'b1;
      $display("reset test done");
      acc(2, 20'h0B0E0, 8'hA5);
      acc(1, 20'h0B0E0, 8'h00);
      acc(2, 20'h0B0C0, 8'hFF);
      acc(1, 20'h0B0C0, 8'h00);
      acc(2, 20'h0B0D0, 8'h3C);
      acc(1, 20'h0B0D0, 8'h00);
      $display("register test done");
      foreach (sms[i]) begin
         acc(2, 20'h0B0C0, sms[i]);
         acc(2, 20'h0B0E0, 8'($random(seed)));
         for (int k = 0; k < 3; k++) begin
            foreach (adr[j]) acc(k, {4'($random(seed)), adr[j]}, 8'($random(seed)));
         end
      end
      $display("decode sweep done");
      final_report();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      $display("MISMATCH at %0t: run did not finish", $time);
      final_report();
   end
endmodule // memory_select_decoder_test
`default_nettype wire

// ### testbench/msd_mcu_model.sv
// bus master model: address, data and active low strobes, one access at a time
// assumes the bench raises go_i and holds it until done_o is seen
`timescale 1ns/100ps
`default_nettype none
module msd_mcu_model (
   input  wire logic        clk_i,
   input  wire logic        go_i,
   input  wire logic [1:0]  kind_i,
   input  wire logic [19:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic [3:0]  hold_i,
   output logic      [19:0] addr_o,
   output logic      [7:0]  data_o,
   output logic             fetch_n_o,
   output logic             rd_n_o,
   output logic             wr_n_o,
   output logic             done_o
);
   int cnt;
   // ------------------------------------------
   // one strobe pulse per request
   // ------------------------------------------
   initial begin
      cnt = 0;
      addr_o = '0;
      data_o = '0;
      {fetch_n_o, rd_n_o, wr_n_o, done_o} = 4'hE;
   end
   // hold_i sets a prompt or slow strobe; idle gap of four edges follows
   always @(posedge clk_i) begin
      done_o <= (cnt == 5);
      if (cnt == 0 && go_i) begin
         addr_o    <= addr_i;
         data_o    <= wdata_i;
         fetch_n_o <= kind_i != 2'd0;
         rd_n_o    <= kind_i != 2'd1;
         wr_n_o    <= kind_i != 2'd2;
         cnt       <= int'(hold_i) + 4;
      end else if (cnt == 5) begin
         {fetch_n_o, rd_n_o, wr_n_o} <= 3'h7;
         cnt    <= 4;
      end else if (cnt > 0) begin
         // released data bus must not keep its old value
         if (cnt == 3) data_o <= ~data_o;
         cnt <= cnt - 1;
      end
   end
endmodule // msd_mcu_model
`default_nettype wire

// ### verilog/msd_decoder.sv
// memory select decoder: flash, boot and sram selects, page and space mapping registers
// assumes asynchronous bus pins; all of them pass a two stage synchroniser first
`timescale 1ns/100ps
`default_nettype none
`include "msd_regs.svh"
module msd_decoder
   import msd_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [19:0] addr_i,
   input  wire logic [7:0]  data_i,
   input  wire logic        program_fetch_strobe_n_i,
   input  wire logic        read_strobe_n_i,
   input  wire logic        write_strobe_n_i,
   input  wire logic        power_down_input_i,
   input  wire logic        ext_addr_mode_i,
   input  wire logic [23:0] port_in_i,
   input  wire logic [2:0]  port_d_in_i,
   input  wire logic [15:0] cell_feedback_i,
   input  wire logic        boot_ready_i,
   output logic [7:0]       main_flash_sector_select_o,
   output logic [3:0]       boot_sector_select_o,
   output logic             sram_select_o,
   output logic             config_register_space_o,
   output logic             periph_io_select_o,
   output logic [7:0]       page_outputs_o,
   output logic [7:0]       space_mapping_o,
   output msd_lbus_t        logic_bus_o,
   output logic [7:0]       data_o,
   output logic             data_oe_o
);

   // --------------------------------------------------------------
   // synchroniser, first stage read only by the second
   // --------------------------------------------------------------
   msd_pins_t pins_w;
   msd_pins_t s1_r;
   msd_pins_t s2_r;
   logic      wr_d_r;

   assign pins_w = '{addr: addr_i, data: data_i, fetch: ~program_fetch_strobe_n_i,
                     rd: ~read_strobe_n_i, wr: ~write_strobe_n_i, pwr_dn: power_down_input_i,
                     ext: ext_addr_mode_i, port_in: port_in_i, pd_in: port_d_in_i,
                     fb: cell_feedback_i, rdy: boot_ready_i};

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_r   <= '0;
         s2_r   <= '0;
         wr_d_r <= 1'b0;
      end else begin
         s1_r   <= pins_w;
         s2_r   <= s1_r;
         wr_d_r <= s2_r.wr;
      end
   end

   // --------------------------------------------------------------
   // region decode
   // --------------------------------------------------------------
   function automatic logic tag_hit(input logic [15:0] a, input logic [15:0] mask,
                                    input logic [15:0] tag);
      tag_hit = ((a & mask) == tag);
   endfunction

   logic [7:0]  page_r;
   logic [7:0]  smap_r;
   logic [15:0] a_w;
   logic        data_acc_w;
   logic        sram_hit_w;
   logic        cfg_hit_w;
   logic        pio_hit_w;
   logic        boot_hit_w;
   logic        main_hit_w;
   logic        lvl1_w;
   logic        sram_ok_w;
   logic        boot_ok_w;
   logic        main_ok_w;
   logic [2:0]  main_idx_w;
   logic [1:0]  boot_idx_w;
   logic        wr_rise_w;
   logic        page_wr_w;
   logic        smap_wr_w;

   assign a_w        = s2_r.addr[15:0];
   assign data_acc_w = s2_r.rd | s2_r.wr;
   // region tags are fixed; sizes keep each sector within its physical size
   assign sram_hit_w  = tag_hit(a_w, 16'hF800, {`MSD_SRAM_TAG, 11'h000});
   assign cfg_hit_w   = tag_hit(a_w, 16'hFF00, {`MSD_CFG_TAG, 8'h00});
   assign pio_hit_w   = tag_hit(a_w, 16'hF000, {`MSD_PIO_TAG, 12'h000}) & smap_r[`MSD_SMAP_PIO_ON];
   assign boot_hit_w  = tag_hit(a_w, 16'hE000, {`MSD_BOOT_TAG, 13'h0000});
   assign main_hit_w  = tag_hit(a_w, 16'h8000, {`MSD_MAIN_TAG, 15'h0000});
   // page bits pick among main sectors, so paging extends the reach
   assign main_idx_w  = {page_r[1:0], a_w[14]};
   assign boot_idx_w  = a_w[12:11];

   // strobe gating by space mapping, sram always open to data strobes
   assign sram_ok_w = (s2_r.fetch & smap_r[`MSD_SMAP_SRAM_FETCH]) | data_acc_w;
   assign boot_ok_w = (s2_r.fetch & smap_r[`MSD_SMAP_BOOT_FETCH]) |
                      (data_acc_w & smap_r[`MSD_SMAP_BOOT_READ]);
   assign main_ok_w = (s2_r.fetch & smap_r[`MSD_SMAP_MAIN_FETCH]) |
                      (data_acc_w & smap_r[`MSD_SMAP_MAIN_READ]);

   // level one masks levels two and three, level two masks three
   assign lvl1_w = sram_hit_w | cfg_hit_w | pio_hit_w;

   // --------------------------------------------------------------
   // register access in config space
   // --------------------------------------------------------------
   assign wr_rise_w = s2_r.wr & ~wr_d_r;
   assign page_wr_w = wr_rise_w & cfg_hit_w & (a_w[7:0] == `MSD_PAGE_OFS);
   assign smap_wr_w = wr_rise_w & cfg_hit_w & (a_w[7:0] == `MSD_SMAP_OFS);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         page_r <= `MSD_PAGE_RST;
         smap_r <= `MSD_SMAP_RST;
      end else begin
         if (page_wr_w) begin
            page_r <= s2_r.data;
         end
         if (smap_wr_w) begin
            smap_r <= s2_r.data & `MSD_SMAP_WMASK;
         end
      end
   end

   // --------------------------------------------------------------
   // registered outputs
   // --------------------------------------------------------------
   logic [7:0] main_nxt;
   logic [3:0] boot_nxt;
   logic       sram_nxt;
   logic       rd_page_w;
   logic       rd_smap_w;
   msd_lbus_t  lbus_nxt;

   always_comb begin
      main_nxt = 8'h00;
      boot_nxt = 4'h0;
      if (!lvl1_w && boot_hit_w && boot_ok_w) begin
         boot_nxt[boot_idx_w] = 1'b1;
      end else if (!lvl1_w && !boot_hit_w && main_hit_w && main_ok_w) begin
         main_nxt[main_idx_w] = 1'b1;
      end
   end

   assign sram_nxt  = sram_hit_w & sram_ok_w;
   assign rd_page_w = s2_r.rd & cfg_hit_w & (a_w[7:0] == `MSD_PAGE_OFS);
   assign rd_smap_w = s2_r.rd & cfg_hit_w & (a_w[7:0] == `MSD_SMAP_OFS);

   // extended mode shifts the array address window up by four bits
   assign lbus_nxt = '{addr: s2_r.ext ? s2_r.addr[19:4] : s2_r.addr[15:0],
                       bus_ctl: {s2_r.fetch, s2_r.rd, s2_r.wr}, rst: 1'b0, pwr_dn: s2_r.pwr_dn,
                       port_in: s2_r.port_in, pd_in: s2_r.pd_in, page: page_r,
                       fb: s2_r.fb, rdy: s2_r.rdy};

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         main_flash_sector_select_o <= 8'h00;
         boot_sector_select_o       <= 4'h0;
         sram_select_o              <= 1'b0;
         config_register_space_o    <= 1'b0;
         periph_io_select_o         <= 1'b0;
         page_outputs_o             <= `MSD_PAGE_RST;
         space_mapping_o            <= `MSD_SMAP_RST;
         logic_bus_o                <= '0;
         data_o                     <= 8'h00;
         data_oe_o                  <= 1'b0;
      end else begin
         main_flash_sector_select_o <= main_nxt;
         boot_sector_select_o       <= boot_nxt;
         sram_select_o              <= sram_nxt;
         config_register_space_o    <= cfg_hit_w & data_acc_w;
         periph_io_select_o         <= pio_hit_w & data_acc_w;
         page_outputs_o             <= page_r;
         space_mapping_o            <= smap_r;
         logic_bus_o                <= lbus_nxt;
         data_o                     <= rd_page_w ? page_r : (rd_smap_w ? smap_r : 8'h00);
         data_oe_o                  <= rd_page_w | rd_smap_w;
      end
   end

   // --------------------------------------------------------------
   // assertions
   // --------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   a_one_select: assert property ($onehot0({main_flash_sector_select_o, boot_sector_select_o,
      sram_select_o, config_register_space_o, periph_io_select_o}))
      else $error("more than one memory select");
   a_boot_beats_main: assert property ((boot_hit_w && main_hit_w && !lvl1_w && boot_ok_w)
      |=> boot_sector_select_o != 4'h0 && main_flash_sector_select_o == 8'h00)
      else $error("boot lost an overlap");
   a_lvl1_beats_flash: assert property (lvl1_w |=> boot_sector_select_o == 4'h0 &&
      main_flash_sector_select_o == 8'h00)
      else $error("flash won over level one");
   a_sram_only_select: assert property (sram_select_o |-> $past(sram_hit_w) &&
      ($past(data_acc_w) || ($past(s2_r.fetch) && $past(smap_r[`MSD_SMAP_SRAM_FETCH]))))
      else $error("sram selected without cause");
   a_fetch_main_gate: assert property ((main_hit_w && !lvl1_w && !boot_hit_w && s2_r.fetch &&
      !data_acc_w) |=> (main_flash_sector_select_o != 8'h00) == $past(smap_r[`MSD_SMAP_MAIN_FETCH]))
      else $error("fetch mapping of main flash wrong");
   a_page_write: assert property (page_wr_w |=> page_r == $past(s2_r.data) ##1
      page_outputs_o == $past(s2_r.data, 2))
      else $error("page write not taken");
   a_page_hold: assert property (!page_wr_w |=> $stable(page_r))
      else $error("page changed without write");
   a_smap_write: assert property (smap_wr_w |=> smap_r == ($past(s2_r.data) & `MSD_SMAP_WMASK) &&
      smap_r[6:5] == 2'b00)
      else $error("space mapping write wrong");
   a_page_in_select: assert property ((main_hit_w && !lvl1_w && !boot_hit_w && main_ok_w)
      |=> main_flash_sector_select_o[{$past(page_r[1:0]), $past(a_w[14])}])
      else $error("page not used in main decode");
   a_ext_window: assert property (##1 logic_bus_o.addr ==
      ($past(s2_r.ext) ? $past(s2_r.addr[19:4]) : $past(s2_r.addr[15:0])))
      else $error("logic bus address window wrong");

   c_sram_over_flash: cover property (sram_hit_w && boot_hit_w && main_hit_w && data_acc_w);
   c_page_then_main: cover property (page_wr_w ##[1:20] main_flash_sector_select_o[7]);
   c_smap_rewrite: cover property (smap_wr_w ##1 smap_r == 8'h9F);
   c_page_read: cover property (rd_page_w ##1 data_oe_o);

endmodule // msd_decoder
`default_nettype wire

// ### verilog/msd_pkg.sv
// types of the memory select decoder
// assumes msd_regs.svh sits in the include path
`default_nettype none
package msd_pkg;
   `include "msd_regs.svh"

   // --------------------------------------------------------------
   // pin group of the bus side, strobes already active high
   // --------------------------------------------------------------
   typedef struct packed {
      logic [19:0] addr;
      logic [7:0]  data;
      logic        fetch;
      logic        rd;
      logic        wr;
      logic        pwr_dn;
      logic        ext;
      logic [23:0] port_in;
      logic [2:0]  pd_in;
      logic [15:0] fb;
      logic        rdy;
   } msd_pins_t;

   // --------------------------------------------------------------
   // 73 signal input bus of the logic arrays
   // --------------------------------------------------------------
   typedef struct packed {
      logic [15:0] addr;
      logic [2:0]  bus_ctl;
      logic        rst;
      logic        pwr_dn;
      logic [23:0] port_in;
      logic [2:0]  pd_in;
      logic [7:0]  page;
      logic [15:0] fb;
      logic        rdy;
   } msd_lbus_t;
endpackage
`default_nettype wire

// ### verilog/msd_regs.svh
// constants of the memory select decoder: offsets, fields, resets, region tags
// assumes it is included by bare name from the package and the decoder
//
// What this block does
// - sram works only while its select is high
// - boot sector wins over overlapped main sector
// - sram, config and periph io beat any flash
// - three priority levels, level one highest
// - each memory reached by fetch, read or both
// - space mapping bit layout, bits six five unused
// - mapping preset at reset, rewritable, acts immediately
// - eight bit page register extends addressing
// - page register read and write at E0h
// - page outputs are terms of select decode
// - page bits also go to general logic
// - logic input bus carries 73 signals
// - extended mode feeds address bits 19 to 4
`ifndef MSD_REGS_SVH
`define MSD_REGS_SVH

// --------------------------------------------------------------
// register offsets inside config register space
// --------------------------------------------------------------
`define MSD_PAGE_OFS      8'hE0
`define MSD_SMAP_OFS      8'hC0
// --------------------------------------------------------------
// reset values and space mapping fields
// --------------------------------------------------------------
`define MSD_PAGE_RST      8'h00
`define MSD_SMAP_RST         8'h0C
`define MSD_SMAP_WMASK       8'h9F
`define MSD_SMAP_SRAM_FETCH  0
`define MSD_SMAP_BOOT_FETCH  1
`define MSD_SMAP_MAIN_FETCH  2
`define MSD_SMAP_BOOT_READ   3
`define MSD_SMAP_MAIN_READ   4
`define MSD_SMAP_PIO_ON      7
// --------------------------------------------------------------
// decode regions (address tags)
// --------------------------------------------------------------
`define MSD_SRAM_TAG      5'h10
`define MSD_CFG_TAG       8'hB0
`define MSD_PIO_TAG       4'hC
`define MSD_BOOT_TAG      3'h4
`define MSD_MAIN_TAG      1'h1

`endif
